// ### rtl/fblcr_host.sv
// Purpose: Host controller issuing flash command sequences from AXI4-Lite registers
// Assumes: Single 100 MHz clock; flash data pins arrive asynchronously
// Notes: One flash command at a time; software polls busy before the next
//
// Local design decisions: the AXI4-Lite register port and the register offsets.
`timescale 1ns/1ns
`default_nettype none

module fblcr_host
   import fblcr_pkg::*;
(
   // Clock and reset
   input wire logic clk_sys_i,
   input wire logic nrst_i,
   // AXI4-Lite slave
   input wire logic [7:0] s_axi_awaddr_i,
   input wire logic s_axi_awvalid_i,
   output logic s_axi_awready_o,
   input wire logic [31:0] s_axi_wdata_i,
   input wire logic [3:0] s_axi_wstrb_i,
   input wire logic s_axi_wvalid_i,
   output logic s_axi_wready_o,
   output logic [1:0] s_axi_bresp_o,
   output logic s_axi_bvalid_o,
   input wire logic s_axi_bready_i,
   input wire logic [7:0] s_axi_araddr_i,
   input wire logic s_axi_arvalid_i,
   output logic s_axi_arready_o,
   output logic [31:0] s_axi_rdata_o,
   output logic [1:0] s_axi_rresp_o,
   output logic s_axi_rvalid_o,
   input wire logic s_axi_rready_i,
   // Flash pins
   output logic flash_rst_n_o,
   output logic flash_ce_n_o,
   output logic flash_oe_n_o,
   output logic flash_we_n_o,
   output logic flash_wp_n_o,
   output logic [21:0] flash_addr_o,
   output logic [15:0] flash_dq_o,
   output logic flash_dq_oe_n_o,
   input wire logic [15:0] flash_dq_i
);

   typedef struct packed {
      fblcr_state_t st;
      fblcr_axi_t axi;
      fblcr_pins_t pin;
      logic [TMR_W-1:0] tmr;
      logic [3:0] op;
      logic [21:0] addr;
      logic [15:0] wdata;
      logic [15:0] rdata;
      logic [15:0] sync1;
      logic [15:0] sync2;
      logic [1:0] pins;
      logic busy;
      logic refused;
      logic prog_susp;
      logic erase_susp;
      fblcr_c2_t c2;
      logic [15:0] c2_data;
   } fblcr_all_t;

   fblcr_all_t q;
   fblcr_all_t d;
   logic [31:0] wmask;
   logic [31:0] wval;
   logic start;
   logic bad;
   logic [15:0] c1;

   // Byte lanes of a write
   assign wmask = {{8{s_axi_wstrb_i[3]}}, {8{s_axi_wstrb_i[2]}},
                   {8{s_axi_wstrb_i[1]}}, {8{s_axi_wstrb_i[0]}}};

   // Next-state logic: bus slave, command decode, pin sequencer
   always_comb begin
      d = q;
      wval = 32'h0000_0000;
      start = 1'b0;
      bad = 1'b0;
      c1 = CC_READ_ARRAY;
      // Data pins only reach the sequencer through two flops
      d.sync1 = flash_dq_i;
      d.sync2 = q.sync1;

      // Write channel: both address and data taken together
      d.axi.awready = 1'b0;
      d.axi.wready = 1'b0;
      if (s_axi_awvalid_i && s_axi_wvalid_i && !q.axi.bvalid && !q.axi.awready) begin
         d.axi.awready = 1'b1;
         d.axi.wready = 1'b1;
      end
      if (q.axi.bvalid && s_axi_bready_i) begin
         d.axi.bvalid = 1'b0;
      end
      if (q.axi.awready) begin
         d.axi.bvalid = 1'b1;
         wval = s_axi_wdata_i & wmask;
         if (s_axi_awaddr_i == OFS_CMD && s_axi_wstrb_i[0]) begin
            start = 1'b1;
         end else if (s_axi_awaddr_i == OFS_ADDR) begin
            d.addr = (q.addr & ~wmask[21:0]) | wval[21:0];
         end else if (s_axi_awaddr_i == OFS_WDATA) begin
            d.wdata = (q.wdata & ~wmask[15:0]) | wval[15:0];
         end else if (s_axi_awaddr_i == OFS_STATUS) begin
            if (wval[ST_REFUSED]) begin
               d.refused = 1'b0;
            end
         end else if (s_axi_awaddr_i == OFS_PINS && s_axi_wstrb_i[0]) begin
            d.pins = wval[1:0];
         end
      end

      // Read channel: answer one cycle after the address is taken
      d.axi.arready = 1'b0;
      if (q.axi.rvalid && s_axi_rready_i) begin
         d.axi.rvalid = 1'b0;
      end
      if (s_axi_arvalid_i && !q.axi.rvalid && !q.axi.arready) begin
         d.axi.arready = 1'b1;
      end
      if (q.axi.arready) begin
         d.axi.rvalid = 1'b1;
         d.axi.rdata = 32'h0000_0000;
         if (s_axi_araddr_i == OFS_CMD) begin
            d.axi.rdata[3:0] = q.op;
         end else if (s_axi_araddr_i == OFS_ADDR) begin
            d.axi.rdata[21:0] = q.addr;
         end else if (s_axi_araddr_i == OFS_WDATA) begin
            d.axi.rdata[15:0] = q.wdata;
         end else if (s_axi_araddr_i == OFS_STATUS) begin
            d.axi.rdata[ST_BUSY] = q.busy;
            d.axi.rdata[ST_REFUSED] = q.refused;
            d.axi.rdata[ST_PROG_SUSP] = q.prog_susp;
            d.axi.rdata[ST_ERASE_SUSP] = q.erase_susp;
         end else if (s_axi_araddr_i == OFS_RDATA) begin
            d.axi.rdata[15:0] = q.rdata;
         end else if (s_axi_araddr_i == OFS_PINS) begin
            d.axi.rdata[1:0] = q.pins;
         end
      end

      // Static pins follow the pin-control register
      d.pin.wp_n = q.pins[PIN_WP_HIGH];
      d.pin.rst_n = !q.pins[PIN_RST_ASSERT];

      // Command decode: table holds only defined codes
      if (start) begin
         d.op = wval[3:0];
         d.c2 = C2_NONE;
         d.c2_data = q.wdata;
         case (wval[3:0])
            OP_READ_ARRAY: c1 = CC_READ_ARRAY;
            OP_READ_ID: begin
               c1 = CC_READ_ID;
               d.c2 = C2_READ;
            end
            OP_READ_STATUS: begin
               c1 = CC_READ_STATUS;
               d.c2 = C2_READ;
            end
            OP_CLEAR_STATUS: c1 = CC_CLEAR_STATUS;
            OP_BLOCK_ERASE: begin
               c1 = CC_BLOCK_ERASE;
               d.c2 = C2_WRITE;
               d.c2_data = CC_CONFIRM;
            end
            OP_CHIP_ERASE: begin
               c1 = CC_CHIP_ERASE;
               d.c2 = C2_WRITE;
               d.c2_data = CC_CONFIRM;
            end
            OP_PROGRAM: begin
               c1 = q.wdata[15] ? CC_PROGRAM_ALT : CC_PROGRAM;
               d.c2 = C2_WRITE;
               d.c2_data = {1'b0, q.wdata[14:0]};
            end
            OP_PB_SETUP: begin
               c1 = CC_PAGE_PROGRAM;
               d.c2 = C2_WRITE;
            end
            OP_PB_WORD: c1 = q.wdata;
            OP_PB_CONFIRM: c1 = CC_CONFIRM;
            OP_SUSP_PROG: begin
               c1 = CC_SUSPEND;
               d.prog_susp = 1'b1;
            end
            OP_SUSP_ERASE: begin
               c1 = CC_SUSPEND;
               d.erase_susp = 1'b1;
            end
            OP_RESUME: begin
               c1 = CC_CONFIRM;
               // Program always resumes ahead of a suspended erase
               if (q.prog_susp) begin
                  d.prog_susp = 1'b0;
               end else begin
                  d.erase_susp = 1'b0;
               end
            end
            OP_LOCK: begin
               c1 = CC_LOCK_SETUP;
               d.c2 = C2_WRITE;
               bad = q.wdata != CC_SET_LOCK && q.wdata != CC_CONFIRM
                     && q.wdata != CC_SET_LOCKDOWN;
            end
            OP_OTP_PROGRAM: begin
               c1 = CC_OTP_PROGRAM;
               d.c2 = C2_WRITE;
               bad = q.erase_susp;
            end
            default: begin
               c1 = CC_LOCK_SETUP;
               d.c2 = C2_WRITE;
               d.c2_data = CC_PCR_CONFIRM;
            end
         endcase
         if (q.busy || bad) begin
            d.op = q.op;
            d.c2 = q.c2;
            d.c2_data = q.c2_data;
            d.prog_susp = q.prog_susp;
            d.erase_susp = q.erase_susp;
            d.refused = 1'b1;
         end else begin
            d.busy = 1'b1;
            d.st = S_WE_LOW;
            d.tmr = TMR_W'(WE_LOW_CYC);
            d.pin.ce_n = 1'b0;
            d.pin.we_n = 1'b0;
            d.pin.dq = c1;
            d.pin.dq_oe_n = 1'b0;
            // Partition code sits on the low address lines
            d.pin.addr = (wval[3:0] == OP_PCR_SET) ? {q.addr[21:16], q.wdata} : q.addr;
         end
      end

      // Pin sequencer
      case (q.st)
         S_IDLE: begin
         end
         S_WE_LOW: begin
            d.tmr = q.tmr - 1'b1;
            if (q.tmr == TMR_W'(1)) begin
               d.st = S_WE_HIGH;
               d.tmr = TMR_W'(WE_HIGH_CYC);
               // Strobe rises before select; data still held past it
               d.pin.we_n = 1'b1;
            end
         end
         S_WE_HIGH: begin
            d.tmr = q.tmr - 1'b1;
            d.pin.ce_n = 1'b1;
            if (q.tmr == TMR_W'(1)) begin
               d.pin.dq_oe_n = 1'b1;
               d.c2 = C2_NONE;
               d.st = S_IDLE;
               d.busy = 1'b0;
               // Address left unchanged for the second cycle
               if (q.c2 == C2_WRITE) begin
                  d.st = S_WE_LOW;
                  d.tmr = TMR_W'(WE_LOW_CYC);
                  d.busy = 1'b1;
                  d.pin.ce_n = 1'b0;
                  d.pin.we_n = 1'b0;
                  d.pin.dq = q.c2_data;
                  d.pin.dq_oe_n = 1'b0;
               end else if (q.c2 == C2_READ) begin
                  d.st = S_READ;
                  d.tmr = TMR_W'(READ_CYC);
                  d.busy = 1'b1;
                  d.pin.ce_n = 1'b0;
                  d.pin.oe_n = 1'b0;
               end
            end
         end
         S_READ: begin
            d.tmr = q.tmr - 1'b1;
            if (q.tmr == TMR_W'(1)) begin
               d.rdata = q.sync2;
               d.pin.ce_n = 1'b1;
               d.pin.oe_n = 1'b1;
               d.st = S_IDLE;
               d.busy = 1'b0;
            end
         end
         default: d.st = S_IDLE;
      endcase
   end

   // Single state register
   always_ff @(posedge clk_sys_i) begin
      if (!nrst_i) begin
         q <= '0;
         q.pin.rst_n <= 1'b1;
         q.pin.ce_n <= 1'b1;
         q.pin.oe_n <= 1'b1;
         q.pin.we_n <= 1'b1;
         q.pin.dq_oe_n <= 1'b1;
         q.st <= S_IDLE;
         q.c2 <= C2_NONE;
      end else begin
         q <= d;
      end
   end

   // Outputs straight from the state register; both response codes fixed at 0
   assign s_axi_awready_o = q.axi.awready;
   assign s_axi_wready_o = q.axi.wready;
   assign s_axi_bvalid_o = q.axi.bvalid;
   assign s_axi_bresp_o = 2'h0;
   assign s_axi_arready_o = q.axi.arready;
   assign s_axi_rvalid_o = q.axi.rvalid;
   assign s_axi_rdata_o = q.axi.rdata;
   assign s_axi_rresp_o = 2'h0;
   assign flash_rst_n_o = q.pin.rst_n;
   assign flash_ce_n_o = q.pin.ce_n;
   assign flash_oe_n_o = q.pin.oe_n;
   assign flash_we_n_o = q.pin.we_n;
   assign flash_wp_n_o = q.pin.wp_n;
   assign flash_addr_o = q.pin.addr;
   assign flash_dq_o = q.pin.dq;
   assign flash_dq_oe_n_o = q.pin.dq_oe_n;

endmodule // fblcr_host

`default_nettype wire

// ### shared/fblcr_pkg.sv
// Purpose: Shared constants and types for the flash lock/command host controller
// Assumes: 100 MHz system clock, 32-bit AXI4-Lite register slave
// Notes: Flash pin timing figures are plain defaults, tune per part
package fblcr_pkg;
   // Clock and pin timing
   localparam int CLK_NS = 10;
   localparam int T_WE_LOW_NS = 60;
   localparam int T_WE_HIGH_NS = 30;
   localparam int T_ACCESS_NS = 90;
   localparam int SYNC_STAGES = 2;
   localparam int WE_LOW_CYC = (T_WE_LOW_NS + CLK_NS - 1) / CLK_NS;
   localparam int WE_HIGH_CYC = (T_WE_HIGH_NS + CLK_NS - 1) / CLK_NS;
   localparam int READ_CYC = (T_ACCESS_NS + CLK_NS - 1) / CLK_NS + SYNC_STAGES;
   localparam int TMR_W = 8;

   // Register byte offsets
   localparam logic [7:0] OFS_CMD = 8'h00;
   localparam logic [7:0] OFS_ADDR = 8'h04;
   localparam logic [7:0] OFS_WDATA = 8'h08;
   localparam logic [7:0] OFS_STATUS = 8'h0C;
   localparam logic [7:0] OFS_RDATA = 8'h10;
   localparam logic [7:0] OFS_PINS = 8'h14;

   // Status and pin-control bit positions
   localparam int ST_BUSY = 0;
   localparam int ST_REFUSED = 1;
   localparam int ST_PROG_SUSP = 2;
   localparam int ST_ERASE_SUSP = 3;
   localparam int PIN_WP_HIGH = 0;
   localparam int PIN_RST_ASSERT = 1;

   // Operation numbers written to the command register
   localparam logic [3:0] OP_READ_ARRAY = 4'h0;
   localparam logic [3:0] OP_READ_ID = 4'h1;
   localparam logic [3:0] OP_READ_STATUS = 4'h2;
   localparam logic [3:0] OP_CLEAR_STATUS = 4'h3;
   localparam logic [3:0] OP_BLOCK_ERASE = 4'h4;
   localparam logic [3:0] OP_CHIP_ERASE = 4'h5;
   localparam logic [3:0] OP_PROGRAM = 4'h6;
   localparam logic [3:0] OP_PB_SETUP = 4'h7;
   localparam logic [3:0] OP_PB_WORD = 4'h8;
   localparam logic [3:0] OP_PB_CONFIRM = 4'h9;
   localparam logic [3:0] OP_SUSP_PROG = 4'hA;
   localparam logic [3:0] OP_SUSP_ERASE = 4'hB;
   localparam logic [3:0] OP_RESUME = 4'hC;
   localparam logic [3:0] OP_LOCK = 4'hD;
   localparam logic [3:0] OP_OTP_PROGRAM = 4'hE;
   localparam logic [3:0] OP_PCR_SET = 4'hF;

   // Flash command codes
   localparam logic [15:0] CC_READ_ARRAY = 16'h00FF;
   localparam logic [15:0] CC_READ_ID = 16'h0090;
   localparam logic [15:0] CC_READ_STATUS = 16'h0070;
   localparam logic [15:0] CC_CLEAR_STATUS = 16'h0050;
   localparam logic [15:0] CC_BLOCK_ERASE = 16'h0020;
   localparam logic [15:0] CC_CHIP_ERASE = 16'h0030;
   localparam logic [15:0] CC_CONFIRM = 16'h00D0;
   localparam logic [15:0] CC_PROGRAM = 16'h0040;
   localparam logic [15:0] CC_PROGRAM_ALT = 16'h0010;
   localparam logic [15:0] CC_PAGE_PROGRAM = 16'h00E8;
   localparam logic [15:0] CC_SUSPEND = 16'h00B0;
   localparam logic [15:0] CC_LOCK_SETUP = 16'h0060;
   localparam logic [15:0] CC_SET_LOCK = 16'h0001;
   localparam logic [15:0] CC_SET_LOCKDOWN = 16'h002F;
   localparam logic [15:0] CC_OTP_PROGRAM = 16'h00C0;
   localparam logic [15:0] CC_PCR_CONFIRM = 16'h0004;

   typedef enum logic [1:0] {C2_NONE, C2_WRITE, C2_READ} fblcr_c2_t;
   typedef enum logic [2:0] {S_IDLE, S_WE_LOW, S_WE_HIGH, S_READ} fblcr_state_t;

   // Flash pin drive
   typedef struct packed {
      logic rst_n;
      logic ce_n;
      logic oe_n;
      logic we_n;
      logic wp_n;
      logic [21:0] addr;
      logic [15:0] dq;
      logic dq_oe_n;
   } fblcr_pins_t;

   // AXI4-Lite slave answer side
   typedef struct packed {
      logic awready;
      logic wready;
      logic bvalid;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
   } fblcr_axi_t;
endpackage

// ### test/fblcr_chk.sv
// Purpose: Bus and flash pin checks for the flash host controller
// Assumes: One clock domain, synchronous active-low reset
// Notes: Setup tracking assumes program data never equals a setup code
`timescale 1ns/1ns
`default_nettype none
module fblcr_chk
   import fblcr_pkg::*;
(
   // Clock, reset and bus handshakes
   input wire logic clk_sys_i, nrst_i, s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i,
   input wire logic s_axi_arvalid_i, s_axi_rready_i, s_axi_awready_o, s_axi_wready_o,
   input wire logic s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o,
   input wire logic [1:0] s_axi_bresp_o,
   input wire logic [31:0] s_axi_rdata_o,
   // Flash pins
   input wire logic flash_ce_n_o, flash_oe_n_o, flash_we_n_o, flash_dq_oe_n_o,
   input wire logic [21:0] flash_addr_o,
   input wire logic [15:0] flash_dq_o
);
   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (!nrst_i);
   logic first_q;
   logic [21:0] addr1_q;
   // Remember address of a setup cycle so the second cycle can be compared
   always_ff @(posedge clk_sys_i) begin
      if (!nrst_i) begin
         first_q <= 1'b0;
      end else if ($fell(flash_we_n_o)) begin
         first_q <= flash_dq_o inside {CC_LOCK_SETUP, CC_BLOCK_ERASE, CC_CHIP_ERASE,
            CC_PROGRAM, CC_PROGRAM_ALT, CC_OTP_PROGRAM, CC_PAGE_PROGRAM};
         addr1_q <= flash_addr_o;
      end
   end
   a_addr_repeat: assert property ($fell(flash_we_n_o) && first_q |->
      flash_addr_o == addr1_q) else $error("second cycle address differs");
   a_data_hold: assert property ($rose(flash_we_n_o) |-> !flash_ce_n_o &&
      !flash_dq_oe_n_o && $stable(flash_dq_o) && $stable(flash_addr_o) ##1 flash_ce_n_o)
      else $error("data not held at strobe rise");
   a_we_pulse: assert property ($fell(flash_we_n_o) |->
      (!flash_we_n_o && !flash_ce_n_o) [*6] ##1 flash_we_n_o) else $error("write pulse length");
   a_oe_we_apart: assert property (flash_oe_n_o || flash_we_n_o)
      else $error("output and write enable low together");
   a_write_answer: assert property (s_axi_awvalid_i && s_axi_wvalid_i && !s_axi_bvalid_o &&
      !s_axi_awready_o |=> s_axi_awready_o && s_axi_wready_o ##1 s_axi_bvalid_o)
      else $error("write not answered");
   a_bvalid_hold: assert property (s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o)
      else $error("bvalid dropped early");
   a_read_answer: assert property (s_axi_arvalid_i && !s_axi_rvalid_o && !s_axi_arready_o
      |=> s_axi_arready_o ##1 s_axi_rvalid_o) else $error("read not answered");
   a_rvalid_hold: assert property (s_axi_rvalid_o && !s_axi_rready_i |=> s_axi_rvalid_o &&
      $stable(s_axi_rdata_o)) else $error("read data not held");
   a_resp_okay: assert property (s_axi_bvalid_o |-> s_axi_bresp_o == 2'h0)
      else $error("write response not okay");
   c_write: cover property (s_axi_bvalid_o && s_axi_bready_i);
   c_read: cover property (s_axi_rvalid_o && s_axi_rready_i);
   c_lock: cover property ($fell(flash_we_n_o) && flash_dq_o == CC_LOCK_SETUP);
endmodule // fblcr_chk
`default_nettype wire

// ### test/fblcr_flash.sv
// Purpose: Behavioural flash device with per-block lock states
// Assumes: 64 blocks picked by address bits 21..16
// Notes: Program and erase only report protection, no array contents
`timescale 1ns/1ns
`default_nettype none
module fblcr_flash (
   // Host-driven pins
   input wire logic rst_n_i, ce_n_i, oe_n_i, we_n_i, wp_i,
   input wire logic [21:0] addr_i,
   input wire logic [15:0] dq_i,
   // Data back to the host
   output logic [15:0] dq_o
);
   logic lk[64] = '{default: 1'b1};
   logic ld[64] = '{default: 1'b0};
   logic h[64] = '{default: 1'b0};
   logic [7:0] pend = 8'h00, rmode = 8'hFF, d, pbn = 8'h00;
   logic sr1 = 1'b0, wp_q;
   logic [15:0] last = 16'h0000, pcr = 16'h0000;
   wire logic wr_act = !ce_n_i && !we_n_i;
   wire logic [5:0] b = addr_i[21:16];
   wire logic [15:0] rd = (rmode == 8'h90) ? {14'h0000, ld[b], lk[b]} :
      (rmode == 8'h70) ? {8'h00, 1'b1, 5'h00, sr1, 1'b0} : addr_i[15:0];
   // Reset and protect edges; h remembers that a held-down block came from 110
   always @(rst_n_i, wp_i) begin
      if (rst_n_i !== 1'b1) begin
         for (int i = 0; i < 64; i++) begin
            lk[i] = 1'b1;
            ld[i] = 1'b0;
            h[i] = 1'b0;
         end
         pend = 8'h00;
         sr1 = 1'b0;
      end else if (wp_i !== wp_q) begin
         for (int i = 0; i < 64; i++) begin
            if (ld[i] && wp_i) lk[i] = !h[i];
            else if (ld[i]) begin
               h[i] = !lk[i];
               lk[i] = 1'b1;
            end
         end
      end
      wp_q = wp_i;
   end
   // Command cycles end on whichever strobe rises first
   always @(negedge wr_act) begin
      d = dq_i[7:0];
      if (rst_n_i === 1'b1 && (ce_n_i & we_n_i) === 1'b0) begin
         if (pend == 8'h00) begin
            if (d inside {8'h60, 8'h20, 8'h30, 8'h40, 8'h10, 8'hC0, 8'hE8}) pend = d;
            if (d inside {8'h90, 8'h70, 8'hFF}) rmode = d;
            if (d == 8'h50) sr1 = 1'b0;
            // Nothing runs long here, so a suspend never catches chip erase or OTP
            if (d == 8'hB0) pend = 8'h00;
         end else if (pend == 8'hE8) begin
            pbn = d + 8'h01;
            pend = 8'hE9;
         end else if (pend == 8'hE9) begin
            // Count down the loaded words, then the confirm checks the lock
            if (pbn != 8'h00) begin
               pbn = pbn - 8'h01;
            end else begin
               if (d == 8'hD0 && lk[b]) sr1 = 1'b1;
               pend = 8'h00;
            end
         end else begin
            if (pend == 8'h60 && d == 8'h04) pcr = addr_i[15:0];
            if (pend == 8'h60 && d == 8'h01) lk[b] = 1'b1;
            if (pend == 8'h60 && d == 8'hD0 && (wp_i || !ld[b])) lk[b] = 1'b0;
            if (pend == 8'h60 && d == 8'h2F) begin
               ld[b] = 1'b1;
               lk[b] = 1'b1;
               h[b] = 1'b0;
            end
            if (pend inside {8'h20, 8'h30, 8'h40, 8'h10} && lk[b]) sr1 = 1'b1;
            pend = 8'h00;
         end
      end
   end
   // Released bus shows the inverse of the last word, never stale data
   always @(posedge oe_n_i) last = rd;
   assign dq_o = (!ce_n_i && !oe_n_i) ? rd : ~last;
endmodule // fblcr_flash
`default_nettype wire

// ### test/testbench.sv
// Purpose: Self-checking bench for the flash host controller
// Assumes: Flash model on the pins, AXI4-Lite master tasks below
// Notes: Lock rows start from the power-up locked state
`timescale 1ns/1ns
`default_nettype none
module testbench
   import fblcr_pkg::*;
;
   typedef struct packed {
      logic [1:0] kind;
      logic [15:0] val;
      logic [2:0] st;
      logic sr1;
   } fblcr_row_t;
   logic clk_sys_i, nrst_i, s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i;
   logic s_axi_arvalid_i, s_axi_rready_i, s_axi_awready_o, s_axi_wready_o;
   logic s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o, flash_rst_n_o, flash_ce_n_o;
   logic flash_oe_n_o, flash_we_n_o, flash_wp_n_o, flash_dq_oe_n_o;
   logic [7:0] s_axi_awaddr_i, s_axi_araddr_i;
   logic [31:0] s_axi_wdata_i, s_axi_rdata_o, r;
   logic [3:0] s_axi_wstrb_i;
   logic [1:0] s_axi_bresp_o, s_axi_rresp_o;
   logic [21:0] flash_addr_o;
   logic [15:0] flash_dq_o, flash_dq_i;
   int error_cnt = 0, checks = 0, cyc = 0;
   localparam logic [21:0] BLK = 22'h05_0000;
   // Kind 0 lock code, 1 protect level, 2 program, 3 erase
   fblcr_row_t rows[19] = '{'{0, 16'h00D0, 3'b000, 0}, '{2, 16'h1234, 3'b000, 0},
      '{1, 16'h0001, 3'b100, 0}, '{3, 16'h0000, 3'b100, 0}, '{0, 16'h0001, 3'b101, 0},
      '{2, 16'h9234, 3'b101, 1}, '{1, 16'h0000, 3'b001, 0}, '{3, 16'h0000, 3'b001, 1},
      '{0, 16'h002F, 3'b011, 0}, '{0, 16'h00D0, 3'b011, 0}, '{1, 16'h0001, 3'b111, 0},
      '{0, 16'h00D0, 3'b110, 0}, '{2, 16'h1234, 3'b110, 0}, '{1, 16'h0000, 3'b011, 0},
      '{3, 16'h0000, 3'b011, 1}, '{1, 16'h0001, 3'b110, 0}, '{0, 16'h0001, 3'b111, 0},
      '{1, 16'h0000, 3'b011, 0}, '{1, 16'h0001, 3'b111, 0}};
   fblcr_host DUT (.*);
   fblcr_flash u_flash (.rst_n_i(flash_rst_n_o), .ce_n_i(flash_ce_n_o), .oe_n_i(flash_oe_n_o),
      .we_n_i(flash_we_n_o), .wp_i(flash_wp_n_o), .addr_i(flash_addr_o), .dq_i(flash_dq_o),
      .dq_o(flash_dq_i));
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // Address and data offered together, each released when taken
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
      logic ta, td;
      ta = 1'b0;
      td = 1'b0;
      s_axi_awaddr_i <= a;
      s_axi_wdata_i <= d;
      s_axi_awvalid_i <= 1'b1;
      s_axi_wvalid_i <= 1'b1;
      s_axi_bready_i <= 1'b1;
      while (!(ta && td)) begin
         @(posedge clk_sys_i);
         if (s_axi_awready_o) ta = 1'b1;
         if (s_axi_awready_o) s_axi_awvalid_i <= 1'b0;
         if (s_axi_wready_o) td = 1'b1;
         if (s_axi_wready_o) s_axi_wvalid_i <= 1'b0;
      end
      while (s_axi_bvalid_o !== 1'b1) @(posedge clk_sys_i);
      s_axi_bready_i <= 1'b0;
      @(posedge clk_sys_i);
   endtask
   task automatic axi_rd(input logic [7:0] a, output logic [31:0] d);
      s_axi_araddr_i <= a;
      s_axi_arvalid_i <= 1'b1;
      s_axi_rready_i <= 1'b1;
      do @(posedge clk_sys_i); while (s_axi_arready_o !== 1'b1);
      s_axi_arvalid_i <= 1'b0;
      do @(posedge clk_sys_i); while (s_axi_rvalid_o !== 1'b1);
      d = s_axi_rdata_o;
      s_axi_rready_i <= 1'b0;
      @(posedge clk_sys_i);
   endtask
   // Load address and data, start, then poll busy
   task automatic run_op(input logic [3:0] op, input logic [21:0] a, input logic [15:0] d);
      logic [31:0] s;
      axi_wr(OFS_ADDR, {10'h000, a});
      axi_wr(OFS_WDATA, {16'h0000, d});
      axi_wr(OFS_CMD, {28'h000_0000, op});
      do axi_rd(OFS_STATUS, s); while (s[ST_BUSY] !== 1'b0);
   endtask
   // Read the flash status word, compare the protect bit, then clear it
   task automatic sr_check(input logic e);
      run_op(OP_READ_STATUS, BLK, 16'h0000);
      axi_rd(OFS_RDATA, r);
      check("protect status", r[1], e);
      run_op(OP_CLEAR_STATUS, BLK, 16'h0000);
   endtask
   task automatic close_out();
      $display("Comparisons %0d mismatches %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   initial begin
      clk_sys_i = 1'b0;
      forever #5 clk_sys_i = ~clk_sys_i;
   end
   // Hang guard, far above the expected run length
   always @(posedge clk_sys_i) begin
      cyc++;
      if (cyc == 60000) begin
         error_cnt++;
         close_out();
      end
   end
   initial begin
      {nrst_i, s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i} = 4'h0;
      {s_axi_arvalid_i, s_axi_rready_i, s_axi_awaddr_i, s_axi_araddr_i} = 18'h0_0000;
      s_axi_wdata_i = 32'h0000_0000;
      s_axi_wstrb_i = 4'hF;
      repeat (8) @(posedge clk_sys_i);
      nrst_i <= 1'b1;
      @(posedge clk_sys_i);
      foreach (rows[i]) begin
         case (rows[i].kind)
            2'h0: run_op(OP_LOCK, BLK, rows[i].val);
            2'h1: axi_wr(OFS_PINS, {31'h0000_0000, rows[i].val[0]});
            2'h2: run_op(OP_PROGRAM, BLK, rows[i].val);
            default: run_op(OP_BLOCK_ERASE, BLK, 16'h0000);
         endcase
         if (rows[i].kind[1]) begin
            sr_check(rows[i].sr1);
         end
         run_op(OP_READ_ID, BLK, 16'h0000);
         axi_rd(OFS_RDATA, r);
         check("lock state", {flash_wp_n_o, r[1:0]}, rows[i].st);
      end
      // Flash reset pulse returns the block to locked, not held down
      axi_wr(OFS_PINS, 32'h0000_0003);
      axi_wr(OFS_PINS, 32'h0000_0001);
      run_op(OP_READ_ID, BLK, 16'h0000);
      axi_rd(OFS_RDATA, r);
      check("reset lock", {flash_wp_n_o, r[1:0]}, 3'b101);
      run_op(OP_LOCK, BLK, 16'h0055);
      axi_rd(OFS_STATUS, r);
      check("bad lock code", r[3:0], 4'h2);
      axi_wr(OFS_STATUS, 32'h0000_0002);
      // Both suspended: one-time program refused, program resumed first
      run_op(OP_SUSP_PROG, BLK, 16'h0000);
      run_op(OP_SUSP_ERASE, BLK, 16'h0000);
      run_op(OP_OTP_PROGRAM, 22'h00_0080, 16'h1234);
      axi_rd(OFS_STATUS, r);
      check("otp during suspend", r[3:0], 4'hE);
      axi_wr(OFS_STATUS, 32'h0000_0002);
      run_op(OP_RESUME, BLK, 16'h0000);
      axi_rd(OFS_STATUS, r);
      check("first resume", r[3:0], 4'h8);
      run_op(OP_RESUME, BLK, 16'h0000);
      axi_rd(OFS_STATUS, r);
      check("second resume", r[3:0], 4'h0);
      axi_rd(8'h20, r);
      check("unmapped read", r, 32'h0000_0000);
      // Buffered program of two words into the still locked block is refused
      run_op(OP_PB_SETUP, BLK, 16'h0001);
      run_op(OP_PB_WORD, BLK, 16'h5A5A);
      run_op(OP_PB_WORD, BLK + 22'h00_0001, 16'h5A5A);
      run_op(OP_PB_CONFIRM, BLK, 16'h0000);
      sr_check(1'b1);
      run_op(OP_CHIP_ERASE, BLK, 16'h0000);
      sr_check(1'b1);
      run_op(OP_PCR_SET, BLK, 16'h0300);
      check("partition code", u_flash.pcr, 32'h0000_0300);
      // Controller reset mid-run: pins go idle and registers clear
      nrst_i <= 1'b0;
      repeat (2) @(posedge clk_sys_i);
      nrst_i <= 1'b1;
      @(posedge clk_sys_i);
      check("idle select", flash_ce_n_o, 32'h0000_0001);
      axi_rd(OFS_PINS, r);
      check("pins after reset", r, 32'h0000_0000);
      close_out();
   end
endmodule // testbench
bind fblcr_host fblcr_chk u_chk (.*);
`default_nettype wire
